// [hw/smc_pkg.sv]
package smc_pkg;
   // ----------------------------------------------------------------
   // register offsets (byte addresses on the register bus)
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_TXD = 8'h08;
   localparam logic [7:0] OFS_RXD = 8'h0c;
   localparam logic [7:0] OFS_PAGE = 8'h10;
   localparam logic [7:0] OFS_CLKDIV = 8'h14;
   localparam logic [7:0] OFS_BITIO = 8'h18;
   localparam logic [7:0] OFS_IOBASE = 8'h1c;
   // ----------------------------------------------------------------
   // control register fields and reset values
   // ----------------------------------------------------------------
   localparam int CTRL_SMART = 0;
   localparam int CTRL_RUN = 1;
   localparam int CTRL_CLKMODE = 2;
   localparam int CTRL_SPLIT = 3;
   localparam int CTRL_IRQEN = 4;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] IOBASE_RST = 32'h0000_0000;
   // ----------------------------------------------------------------
   // host status register bits
   // ----------------------------------------------------------------
   localparam int ST_ANALOG = 0;
   localparam int ST_TXFULL = 1;
   localparam int ST_RXFULL = 2;
   localparam int ST_FLAG = 3;
   localparam int ST_W = 4;
   localparam logic [ST_W-1:0] ST_W1C_MASK = 4'hb;
   // ----------------------------------------------------------------
   // page register layout
   // ----------------------------------------------------------------
   localparam int PAGE_W = 10;
   localparam int PG_PROG_LSB = 0;
   localparam int PG_DATA_LSB = 10;
   localparam int PG_GLOB_LSB = 20;
   localparam int OFS_W = 15;
   // ----------------------------------------------------------------
   // bus responses
   // ----------------------------------------------------------------
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   // ----------------------------------------------------------------
   // processor clock timing
   // ----------------------------------------------------------------
   localparam int CLK_NS = 8;
   localparam int FAST_CYCLE_NS = 25;
   localparam int SLOW_CYCLE_NS = 50;
   localparam int FAST_HALF_RAW = FAST_CYCLE_NS / (2 * CLK_NS);
   localparam int SLOW_HALF_RAW = SLOW_CYCLE_NS / (2 * CLK_NS);
   localparam logic [7:0] FAST_HALF =
      8'((FAST_HALF_RAW < 1) ? 1 : FAST_HALF_RAW);
   localparam logic [7:0] SLOW_HALF =
      8'((SLOW_HALF_RAW < 1) ? 1 : SLOW_HALF_RAW);

   typedef enum logic [1:0] {
      ARB_IDLE = 2'b00,
      ARB_HOLD = 2'b01,
      ARB_HOST = 2'b10,
      ARB_PROC = 2'b11
   } smc_arb_t;
endpackage

// [hw/smc_card_ctrl.sv]
`timescale 1ns/1ps
module smc_card_ctrl
   import smc_pkg::*;
#(
   parameter int MEM_AW = 25,
   parameter int HOST_AW = 26
) (
   input wire logic clock, // 125 MHz
   input wire logic rst, // async, active high
   input wire logic [7:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // write strobes
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   input wire logic [7:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read data valid
   input wire logic s_axi_rready, // read data ready
   input wire logic host_req, // host memory request, held to ack
   input wire logic host_we, // host write
   input wire logic host_attr, // host targets attribute memory
   input wire logic host_byte, // host byte access
   input wire logic [HOST_AW-1:0] host_addr, // host byte address
   input wire logic [15:0] host_wdata, // host write data
   output logic host_ack, // host cycle done pulse
   output logic [15:0] host_rdata, // host read data
   input wire logic host_io_req, // host I/O cycle
   input wire logic [15:0] host_io_addr, // host I/O address
   output logic host_io_hit, // I/O cycle decodes to card
   input wire logic proc_req, // processor memory request
   input wire logic proc_we, // processor write
   input wire logic proc_data_space, // data rather than program
   input wire logic proc_global, // global data space
   input wire logic [15:0] proc_addr, // processor word address
   input wire logic [15:0] proc_wdata, // processor write data
   output logic proc_ack, // processor cycle done pulse
   output logic [15:0] proc_rdata, // processor read data
   output logic proc_hold_req, // hold request to processor
   input wire logic proc_hold_acknowledge_n, // low: processor off bus
   output logic proc_reset, // processor reset, active high
   output logic proc_clock, // generated processor clock
   input wire logic proc_flag_output, // processor flag pin
   input wire logic proc_irq4_in, // other fourth-irq source
   output logic proc_external_irq_four, // merged interrupt
   output logic mem_req, // shared memory cycle
   output logic mem_we, // shared memory write
   output logic mem_attr, // attribute memory select
   output logic [1:0] mem_be, // byte enables (low, high)
   output logic [MEM_AW-1:0] mem_addr, // word address
   output logic [15:0] mem_wdata, // write data
   input wire logic mem_ack, // memory cycle done
   input wire logic [15:0] mem_rdata, // memory read data
   input wire logic analog_board_irq, // analog board request
   input wire logic [3:0] analog_board_in, // analog board inputs
   output logic [7:0] analog_board_out, // analog board outputs
   output logic host_irq // single host interrupt line
);
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] apply_strb(input logic [31:0] old,
      input logic [31:0] d, input logic [3:0] s);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) begin
            r[i*8 +: 8] = d[i*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic addr_ok(input logic [7:0] a);
      return (a[1:0] == 2'b00) && (a <= OFS_IOBASE);
   endfunction

   // ----------------------------------------------------------------
   // register bus and register file
   // ----------------------------------------------------------------
   logic awready_reg, awready_next, wready_reg, wready_next;
   logic bvalid_reg, bvalid_next, arready_reg, arready_next;
   logic rvalid_reg, rvalid_next;
   logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
   logic [7:0] awaddr_reg, awaddr_next;
   logic [31:0] wdata_reg, wdata_next, rdata_reg, rdata_next;
   logic [3:0] wstrb_reg, wstrb_next;
   logic [31:0] ctrl_reg, ctrl_next, page_reg, page_next;
   logic [31:0] iobase_reg, iobase_next;
   logic [15:0] txd_reg, txd_next, rxd_reg, rxd_next;
   logic [1:0] div_reg, div_next;
   logic [7:0] bout_reg, bout_next;
   logic [ST_W-1:0] status_reg, status_next;
   logic flag_d_reg, irq_reg, irq4_reg, iohit_reg;
   logic [31:0] rd_mux;

   always_comb begin
      case (s_axi_araddr)
         OFS_CTRL: rd_mux = ctrl_reg;
         OFS_STATUS: rd_mux = {28'h0, status_reg};
         OFS_TXD: rd_mux = {16'h0, txd_reg};
         OFS_RXD: rd_mux = {16'h0, rxd_reg};
         OFS_PAGE: rd_mux = page_reg;
         OFS_CLKDIV: rd_mux = {30'h0, div_reg};
         OFS_BITIO: rd_mux = {20'h0, analog_board_in, bout_reg};
         OFS_IOBASE: rd_mux = iobase_reg;
         default: rd_mux = 32'h0;
      endcase
   end

   always_comb begin
      logic [31:0] nv;
      nv = 32'h0;
      awready_next = awready_reg;
      wready_next = wready_reg;
      bvalid_next = bvalid_reg;
      bresp_next = bresp_reg;
      arready_next = arready_reg;
      rvalid_next = rvalid_reg;
      rresp_next = rresp_reg;
      rdata_next = rdata_reg;
      awaddr_next = awaddr_reg;
      wdata_next = wdata_reg;
      wstrb_next = wstrb_reg;
      ctrl_next = ctrl_reg;
      page_next = page_reg;
      iobase_next = iobase_reg;
      txd_next = txd_reg;
      rxd_next = rxd_reg;
      div_next = div_reg;
      bout_next = bout_reg;
      status_next = status_reg;
      if (s_axi_awvalid && awready_reg) begin
         awaddr_next = s_axi_awaddr;
         awready_next = 1'b0;
      end
      if (s_axi_wvalid && wready_reg) begin
         wdata_next = s_axi_wdata;
         wstrb_next = s_axi_wstrb;
         wready_next = 1'b0;
      end
      // clears first, hardware sets below so a coincident event wins
      if (!awready_reg && !wready_reg && !bvalid_reg) begin
         bvalid_next = 1'b1;
         bresp_next = addr_ok(awaddr_reg) ? RESP_OKAY : RESP_SLVERR;
         case (awaddr_reg)
            OFS_CTRL: ctrl_next = apply_strb(ctrl_reg, wdata_reg,
               wstrb_reg);
            OFS_STATUS: begin
               nv = apply_strb(32'h0, wdata_reg, wstrb_reg);
               status_next = status_reg & ~(nv[ST_W-1:0] & ST_W1C_MASK);
            end
            OFS_TXD: begin
               nv = apply_strb({16'h0, txd_reg}, wdata_reg, wstrb_reg);
               txd_next = nv[15:0];
            end
            OFS_RXD: begin
               nv = apply_strb({16'h0, rxd_reg}, wdata_reg, wstrb_reg);
               rxd_next = nv[15:0];
            end
            OFS_PAGE: page_next = apply_strb(page_reg, wdata_reg,
               wstrb_reg);
            OFS_CLKDIV: begin
               nv = apply_strb({30'h0, div_reg}, wdata_reg, wstrb_reg);
               div_next = nv[1:0];
            end
            OFS_BITIO: begin
               nv = apply_strb({24'h0, bout_reg}, wdata_reg, wstrb_reg);
               bout_next = nv[7:0];
            end
            OFS_IOBASE: iobase_next = apply_strb(iobase_reg, wdata_reg,
               wstrb_reg);
            default: nv = 32'h0;
         endcase
      end
      if (bvalid_reg && s_axi_bready) begin
         bvalid_next = 1'b0;
         awready_next = 1'b1;
         wready_next = 1'b1;
      end
      if (s_axi_arvalid && arready_reg) begin
         arready_next = 1'b0;
         rvalid_next = 1'b1;
         rdata_next = rd_mux;
         rresp_next = addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         if (s_axi_araddr == OFS_RXD) begin
            status_next[ST_RXFULL] = 1'b0;
         end
      end
      if (rvalid_reg && s_axi_rready) begin
         rvalid_next = 1'b0;
         arready_next = 1'b1;
      end
      // event sets after the clears: set wins
      if (!awready_reg && !wready_reg && !bvalid_reg) begin
         if (awaddr_reg == OFS_TXD) status_next[ST_TXFULL] = 1'b1;
         if (awaddr_reg == OFS_RXD) status_next[ST_RXFULL] = 1'b1;
      end
      if (analog_board_irq) begin
         status_next[ST_ANALOG] = 1'b1;
      end
      if (proc_flag_output && !flag_d_reg) begin
         status_next[ST_FLAG] = 1'b1;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         awready_reg <= 1'b1;
         wready_reg <= 1'b1;
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
         arready_reg <= 1'b1;
         rvalid_reg <= 1'b0;
         rresp_reg <= RESP_OKAY;
         rdata_reg <= 32'h0;
         awaddr_reg <= 8'h0;
         wdata_reg <= 32'h0;
         wstrb_reg <= 4'h0;
         ctrl_reg <= CTRL_RST;
         page_reg <= 32'h0;
         iobase_reg <= IOBASE_RST;
         txd_reg <= 16'h0;
         rxd_reg <= 16'h0;
         div_reg <= 2'b00;
         bout_reg <= 8'h0;
         status_reg <= '0;
         flag_d_reg <= 1'b0;
         irq_reg <= 1'b0;
         irq4_reg <= 1'b0;
         iohit_reg <= 1'b0;
      end else begin
         awready_reg <= awready_next;
         wready_reg <= wready_next;
         bvalid_reg <= bvalid_next;
         bresp_reg <= bresp_next;
         arready_reg <= arready_next;
         rvalid_reg <= rvalid_next;
         rresp_reg <= rresp_next;
         rdata_reg <= rdata_next;
         awaddr_reg <= awaddr_next;
         wdata_reg <= wdata_next;
         wstrb_reg <= wstrb_next;
         ctrl_reg <= ctrl_next;
         page_reg <= page_next;
         iobase_reg <= iobase_next;
         txd_reg <= txd_next;
         rxd_reg <= rxd_next;
         div_reg <= div_next;
         bout_reg <= bout_next;
         status_reg <= status_next;
         flag_d_reg <= proc_flag_output;
         irq_reg <= ctrl_reg[CTRL_IRQEN] && (|status_reg);
         irq4_reg <= proc_irq4_in || analog_board_irq;
         iohit_reg <= host_io_req
            && host_io_addr[15:4] == iobase_reg[15:4];
      end
   end

   assign s_axi_awready = awready_reg;
   assign s_axi_wready = wready_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rresp = rresp_reg;
   assign s_axi_rdata = rdata_reg;
   assign analog_board_out = bout_reg;
   assign host_irq = irq_reg;
   assign proc_external_irq_four = irq4_reg;
   assign host_io_hit = iohit_reg;

   // ----------------------------------------------------------------
   // processor reset and clock generation
   // ----------------------------------------------------------------
   logic prst_reg, prst_next, pclk_reg, pclk_next;
   logic mode_reg, mode_next;
   logic [7:0] cnt_reg, cnt_next, half;
   logic running;

   assign running = ctrl_reg[CTRL_SMART] && ctrl_reg[CTRL_RUN];

   always_comb begin
      prst_next = !running;
      // mode only follows the register while the processor is in reset
      mode_next = prst_reg ? ctrl_reg[CTRL_CLKMODE] : mode_reg;
      if (mode_reg) begin
         half = 8'(SLOW_HALF << div_reg);
      end else begin
         half = FAST_HALF;
      end
      cnt_next = cnt_reg;
      pclk_next = pclk_reg;
      if (!running) begin
         cnt_next = 8'h0;
         pclk_next = 1'b0;
      end else if (cnt_reg + 8'h1 >= half) begin
         cnt_next = 8'h0;
         pclk_next = !pclk_reg;
      end else begin
         cnt_next = cnt_reg + 8'h1;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         prst_reg <= 1'b1;
         pclk_reg <= 1'b0;
         mode_reg <= 1'b0;
         cnt_reg <= 8'h0;
      end else begin
         prst_reg <= prst_next;
         pclk_reg <= pclk_next;
         mode_reg <= mode_next;
         cnt_reg <= cnt_next;
      end
   end

   assign proc_reset = prst_reg;
   assign proc_clock = pclk_reg;

   // ----------------------------------------------------------------
   // shared memory arbiter and paging
   // ----------------------------------------------------------------
   smc_arb_t st_reg, st_next;
   logic hreq_reg, hreq_next, hack_reg, hack_next, pack_reg, pack_next;
   logic mreq_reg, mreq_next, mwe_reg, mwe_next, mattr_reg, mattr_next;
   logic [1:0] mbe_reg, mbe_next;
   logic [MEM_AW-1:0] maddr_reg, maddr_next, haddr_w, paddr_w;
   logic [15:0] mwd_reg, mwd_next, hrd_reg, hrd_next, prd_reg, prd_next;
   logic [PAGE_W-1:0] pg;
   logic host_new, proc_new;

   assign host_new = host_req && !hack_reg;
   assign proc_new = proc_req && !pack_reg && running;
   // host sees external memory only, never processor internal ram
   assign haddr_w = MEM_AW'(host_addr[HOST_AW-1:1]);

   always_comb begin
      if (proc_global) begin
         pg = page_reg[PG_GLOB_LSB +: PAGE_W];
      end else if (ctrl_reg[CTRL_SPLIT] && proc_data_space) begin
         pg = page_reg[PG_DATA_LSB +: PAGE_W];
      end else begin
         pg = page_reg[PG_PROG_LSB +: PAGE_W];
      end
      paddr_w = MEM_AW'({pg, proc_addr[OFS_W-1:0]});
   end

   always_comb begin
      st_next = st_reg;
      hreq_next = hreq_reg;
      hack_next = 1'b0;
      pack_next = 1'b0;
      mreq_next = mreq_reg;
      mwe_next = mwe_reg;
      mattr_next = mattr_reg;
      mbe_next = mbe_reg;
      maddr_next = maddr_reg;
      mwd_next = mwd_reg;
      hrd_next = hrd_reg;
      prd_next = prd_reg;
      case (st_reg)
         ARB_IDLE: begin
            if (host_new) begin
               if (running) begin
                  hreq_next = 1'b1;
                  st_next = ARB_HOLD;
               end else begin
                  st_next = ARB_HOST;
               end
               mreq_next = !running;
               mwe_next = host_we && !host_attr;
               mattr_next = host_attr;
               maddr_next = haddr_w;
               if (host_byte || host_attr) begin
                  mbe_next = host_addr[0] ? 2'b10 : 2'b01;
                  mwd_next = {host_wdata[7:0], host_wdata[7:0]};
               end else begin
                  mbe_next = 2'b11;
                  mwd_next = host_wdata;
               end
            end else if (proc_new) begin
               st_next = ARB_PROC;
               mreq_next = 1'b1;
               mwe_next = proc_we && !proc_global;
               mattr_next = proc_global;
               mbe_next = 2'b11;
               maddr_next = paddr_w;
               mwd_next = proc_wdata;
            end
         end
         ARB_HOLD: begin
            if (!proc_hold_acknowledge_n) begin
               mreq_next = 1'b1;
               st_next = ARB_HOST;
            end
         end
         ARB_HOST: begin
            if (mem_ack) begin
               mreq_next = 1'b0;
               hreq_next = 1'b0;
               hack_next = 1'b1;
               st_next = ARB_IDLE;
               if (mattr_reg && mbe_reg == 2'b10) begin
                  hrd_next = 16'h0;
               end else if (mbe_reg == 2'b10) begin
                  hrd_next = {8'h0, mem_rdata[15:8]};
               end else if (mbe_reg == 2'b01) begin
                  hrd_next = {8'h0, mem_rdata[7:0]};
               end else begin
                  hrd_next = mem_rdata;
               end
            end
         end
         ARB_PROC: begin
            if (mem_ack) begin
               mreq_next = 1'b0;
               pack_next = 1'b1;
               prd_next = mem_rdata;
               st_next = ARB_IDLE;
            end
         end
         default: st_next = ARB_IDLE;
      endcase
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         st_reg <= ARB_IDLE;
         hreq_reg <= 1'b0;
         hack_reg <= 1'b0;
         pack_reg <= 1'b0;
         mreq_reg <= 1'b0;
         mwe_reg <= 1'b0;
         mattr_reg <= 1'b0;
         mbe_reg <= 2'b00;
         maddr_reg <= '0;
         mwd_reg <= 16'h0;
         hrd_reg <= 16'h0;
         prd_reg <= 16'h0;
      end else begin
         st_reg <= st_next;
         hreq_reg <= hreq_next;
         hack_reg <= hack_next;
         pack_reg <= pack_next;
         mreq_reg <= mreq_next;
         mwe_reg <= mwe_next;
         mattr_reg <= mattr_next;
         mbe_reg <= mbe_next;
         maddr_reg <= maddr_next;
         mwd_reg <= mwd_next;
         hrd_reg <= hrd_next;
         prd_reg <= prd_next;
      end
   end

   assign proc_hold_req = hreq_reg;
   assign host_ack = hack_reg;
   assign host_rdata = hrd_reg;
   assign proc_ack = pack_reg;
   assign proc_rdata = prd_reg;
   assign mem_req = mreq_reg;
   assign mem_we = mwe_reg;
   assign mem_attr = mattr_reg;
   assign mem_be = mbe_reg;
   assign mem_addr = maddr_reg;
   assign mem_wdata = mwd_reg;
endmodule

// [testbench/smc_chk.sv]
`timescale 1ns/1ps
module smc_chk(
   input wire logic clock, // clock
   input wire logic rst, // reset
   input wire logic host_ack, // host done
   input wire logic proc_ack, // proc done
   input wire logic mem_req, // mem cycle
   input wire logic mem_ack, // mem done
   input wire logic mem_we, // mem write
   input wire logic mem_attr, // attr select
   input wire logic [1:0] mem_be, // lanes
   input wire logic proc_hold_req, // hold
   input wire logic proc_hold_acknowledge_n, // off bus
   input wire logic proc_reset, // proc reset
   input wire logic proc_clock, // proc clock
   input wire logic proc_irq4_in, // irq source
   input wire logic analog_board_irq, // irq source
   input wire logic proc_external_irq_four // merged irq
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   a_host_pulse: assert property (host_ack |=> !host_ack)
      else $error("host ack wider than one cycle");
   a_host_done: assert property (host_ack |-> $past(mem_ack))
      else $error("host ack without memory ack");
   a_attr_ro: assert property (mem_req && mem_attr |-> !mem_we)
      else $error("attribute memory written");
   a_proc_word: assert property (proc_ack |-> $past(mem_be) == 2'b11)
      else $error("processor cycle not a word");
   a_hold_first: assert property ($rose(mem_req) && proc_hold_req
      |-> !$past(proc_hold_acknowledge_n)) else $error("bus taken early");
   a_mem_held: assert property (mem_req && !mem_ack |=> mem_req)
      else $error("memory cycle dropped");
   a_clock_stop: assert property (proc_reset[*2] |-> !proc_clock)
      else $error("clock runs in reset");
   a_irq_merge: assert property (!$past(rst) |->
      proc_external_irq_four == $past(proc_irq4_in | analog_board_irq))
      else $error("merged irq wrong");
   c_host: cover property (host_ack && !proc_reset);
   c_proc: cover property (proc_ack);
   c_hold: cover property ($rose(proc_hold_req));
endmodule

// [testbench/smc_mem_model.sv]
`timescale 1ns/1ps
module smc_mem_model(
   input wire logic clock, // clock
   input wire logic slow, // add wait states
   input wire logic mem_req, // cycle request
   input wire logic mem_we, // write
   input wire logic [1:0] mem_be, // lanes
   input wire logic [24:0] mem_addr, // word address
   input wire logic [15:0] mem_wdata, // write data
   output logic mem_ack, // cycle done
   output logic [15:0] mem_rdata, // read data
   input wire logic proc_hold_req, // hold request
   input wire logic proc_reset, // processor in reset
   output logic proc_hold_acknowledge_n // low: off bus
);
   logic [15:0] mem [0:1023];
   logic [1:0] wt = 2'h0;
   wire [9:0] ix = {mem_addr[16:15], mem_addr[7:0]};
   initial mem_ack = 0;
   initial mem_rdata = 16'h0;
   initial proc_hold_acknowledge_n = 1;
   always @(posedge clock) begin
      proc_hold_acknowledge_n <= !(proc_hold_req || proc_reset);
      mem_ack <= 0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack && slow && wt != 2'h3) wt <= wt + 2'h1;
      else if (mem_req && !mem_ack) begin
         wt <= 2'h0;
         mem_ack <= 1;
         mem_rdata <= mem[ix];
         if (mem_we && mem_be[0]) mem[ix][7:0] <= mem_wdata[7:0];
         if (mem_we && mem_be[1]) mem[ix][15:8] <= mem_wdata[15:8];
      end
   end
endmodule

// [testbench/testbench.sv]
`timescale 1ns/1ps
module testbench;
   import smc_pkg::*;
   logic clock = 0, rst = 1, slow = 0, proc_flag_output = 0;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, host_io_req = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, host_ack, host_io_hit, proc_ack, proc_hold_req;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, analog_board_out;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 0, analog_board_in = 0;
   logic [1:0] s_axi_bresp, s_axi_rresp, mem_be, rresp_q;
   logic host_req = 0, host_we = 0, host_attr = 0, host_byte = 0;
   logic [25:0] host_addr = 0;
   logic [15:0] host_wdata = 0, host_io_addr = 0, proc_addr = 0;
   logic [15:0] proc_wdata = 0, host_rdata, proc_rdata, mem_wdata, mem_rdata;
   logic proc_req = 0, proc_we = 0, proc_data_space = 0, proc_global = 0;
   logic proc_hold_acknowledge_n, proc_reset, proc_clock, proc_irq4_in = 0;
   logic proc_external_irq_four, mem_req, mem_we, mem_attr, mem_ack;
   logic analog_board_irq = 0, host_irq;
   logic [24:0] mem_addr;
   int errors = 0, n_checks = 0;
   time th, tp;
   smc_card_ctrl smc_card_ctrl_inst(.*);
   smc_mem_model smc_mem_model_inst(.*);
   always #4 clock = ~clock;
   task automatic chk(input logic [31:0] got, exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      do begin
         @(posedge clock);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 0;
      @(posedge clock);
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] exp);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do begin
         @(posedge clock);
         if (s_axi_arready) s_axi_arvalid <= 0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 0;
      rresp_q = s_axi_rresp;
      chk(s_axi_rdata, exp);
      @(posedge clock);
   endtask
   task automatic hm(input logic we, at, by, input logic [25:0] a,
                     input logic [15:0] d);
      host_we <= we;
      host_attr <= at;
      host_byte <= by;
      host_addr <= a;
      host_wdata <= d;
      host_req <= 1;
      do @(posedge clock); while (!host_ack);
      host_req <= 0;
      @(posedge clock);
   endtask
   task automatic pm(input logic we, ds, input logic [15:0] a, d);
      proc_we <= we;
      proc_data_space <= ds;
      proc_addr <= a;
      proc_wdata <= d;
      proc_req <= 1;
      do @(posedge clock); while (!proc_ack);
      proc_req <= 0;
      @(posedge clock);
   endtask
   task automatic wrap_up();
      $display("errors=%0d checks=%0d", errors, n_checks);
      if (errors == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      #400000;
      errors++;
      wrap_up();
   end
   initial begin
      repeat (16) @(posedge clock);
      rst <= 0;
      @(posedge clock);
      chk(proc_reset, 1);
      rc(OFS_CTRL, CTRL_RST);
      rc(8'h20, 32'h0);
      chk(rresp_q, RESP_SLVERR);
      hm(1, 0, 0, 26'h100, 16'h1234);
      hm(1, 0, 1, 26'h101, 16'h0056);
      hm(0, 0, 0, 26'h100, 16'h0);
      chk(host_rdata, 16'h5634);
      hm(0, 0, 1, 26'h101, 16'h0);
      chk(host_rdata, 16'h0056);
      hm(1, 1, 0, 26'h100, 16'hbeef);
      hm(0, 1, 0, 26'h100, 16'h0);
      chk(host_rdata, 16'h0034);
      hm(0, 1, 1, 26'h101, 16'h0);
      chk(host_rdata, 16'h0);
      wr(OFS_CTRL, 32'h10);
      analog_board_irq <= 1;
      repeat (3) @(posedge clock);
      chk({host_irq, proc_external_irq_four}, 2'b11);
      analog_board_irq <= 0;
      rc(OFS_STATUS, 32'h1);
      wr(OFS_STATUS, 32'h1);
      wr(OFS_RXD, 32'h77);
      rc(OFS_STATUS, 32'h4);
      rc(OFS_RXD, 32'h77);
      analog_board_in <= 4'h9;
      wr(OFS_BITIO, 32'ha5);
      @(posedge clock);
      chk(analog_board_out, 8'ha5);
      rc(OFS_BITIO, 32'h9a5);
      wr(OFS_IOBASE, 32'h120);
      host_io_addr <= 16'h125;
      host_io_req <= 1;
      repeat (2) @(posedge clock);
      chk(host_io_hit, 1);
      host_io_req <= 0;
      // clock mode stays fast; only set while the processor is in reset
      wr(OFS_CTRL, 32'h13);
      wr(OFS_PAGE, 32'hc02);
      chk(proc_reset, 0);
      pm(1, 0, 16'h10, 16'ha5a5);
      hm(0, 0, 0, 26'h20020, 16'h0);
      chk(host_rdata, 16'ha5a5);
      wr(OFS_CTRL, 32'h1b);
      pm(1, 1, 16'h10, 16'h0f0f);
      hm(0, 0, 0, 26'h30020, 16'h0);
      chk(host_rdata, 16'h0f0f);
      slow <= 1;
      fork
         begin hm(0, 0, 0, 26'h100, 16'h0); th = $time; end
         begin pm(0, 0, 16'h10, 16'h0); tp = $time; end
      join
      chk(th < tp, 1);
      chk(proc_rdata, 16'ha5a5);
      wrap_up();
   end
endmodule
bind smc_card_ctrl smc_chk smc_chk_inst(.clock, .rst, .host_ack, .proc_ack,
   .mem_req, .mem_ack, .mem_we, .mem_attr, .mem_be, .proc_hold_req,
   .proc_hold_acknowledge_n, .proc_reset, .proc_clock, .proc_irq4_in,
   .analog_board_irq, .proc_external_irq_four);
